// file: logic/ec_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef EC_REGS_SVH
`define EC_REGS_SVH
`define ADDR_W          11
`define MAIN_BASE       11'h400
`define FIFO_ADDR       11'h410
`define TEST_ADDR       11'h411
`define OFF_CTRL1       5'h00
`define OFF_CTRL2       5'h01
`define OFF_STATUS      5'h02
`define CTRL1_A_RST     8'h00
`define CTRL1_B_RST     8'h02
`define CTRL2_RST       8'h00
`define MAIN_RST        8'h00
`define TEST_RST        8'h00
`define BIT_PWR         0
`define BIT_GMASK       5
`define BIT_MASK_B      4
`define BIT_MASK_A      3
`define BIT_BIDIR       5
`define BIT_EXTD        0
`define BIT_TONE        0
`define FIFO_EMPTY_VAL  8'hFF
`define INIT_FRAMES     2'h2
`define CLK_PERIOD_NS   100
`define RST_HOLD_NS     100000
`define LOCK_WAIT_NS    500000
`define RST_HOLD_CYC    ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_WAIT_CYC   ((`LOCK_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: logic/ec_pkg.sv
// Shared types of the echo canceller management ends
package ec_pkg;
    typedef enum logic [2:0] {
        H_RESET,
        H_LOCK,
        H_IDLE,
        H_WAIT_ACK,
        H_RELEASE
    } host_state_t;
    typedef logic [7:0] byte_t;
endpackage : ec_pkg

// file: logic/ec_link_if.sv
// Host bus link between the management device and its host
`timescale 1ns/100ps
interface ec_link_if;
    logic [10:0] addr;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  host_data;
    logic        host_data_oe_n;
    logic [7:0]  dev_data;
    logic        dev_data_oe_n;
    logic        ack_n;
    logic        ack_oe_n;
    logic        irq_n;
    logic        irq_oe_n;
    logic        reset_n;
    logic        frame_pulse_in;
    logic        serial_bit_clock;
    logic [7:0]  data_bus;
    logic        ack_line_n;
    logic        irq_line_n;

    // Wire levels with pull-ups on undriven lines
    assign data_bus   = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : 8'hFF);
    assign ack_line_n = ack_oe_n ? 1'b1 : ack_n;
    assign irq_line_n = irq_oe_n ? 1'b1 : irq_n;

    modport device (
        input  addr, cs_n, rd_n, wr_n, data_bus, reset_n, frame_pulse_in, serial_bit_clock,
        output dev_data, dev_data_oe_n, ack_n, ack_oe_n, irq_n, irq_oe_n
    );
    modport host (
        input  data_bus, ack_line_n, irq_line_n, frame_pulse_in,
        output addr, cs_n, rd_n, wr_n, host_data, host_data_oe_n, reset_n
    );
endinterface : ec_link_if

// file: logic/ec_event_fifo.sv
// Interrupt event FIFO holding channel numbers
`timescale 1ns/100ps
module ec_event_fifo #(
    parameter int W     = 5,
    parameter int DEPTH = 64,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic         ref_clk_in,
    input  wire logic         rst_in,
    input  wire logic         clear_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wp_q;
    logic [AW:0]  rp_q;
    logic         push;
    logic         pop;

    assign out_valid_out = (wp_q != rp_q);
    assign in_ready_out  = (wp_q[AW-1:0] != rp_q[AW-1:0]) || (wp_q[AW] == rp_q[AW]);
    assign push          = in_valid_in && in_ready_out && !clear_in;
    assign pop           = out_valid_out && out_ready_in && !clear_in;
    assign out_data_out  = mem_q[rp_q[AW-1:0]];

    // ****************************************
    // Storage
    // ****************************************
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data_in;
        end
    end

    // ****************************************
    // Pointers
    // ****************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_q <= '0;
            rp_q <= '0;
        end else if (clear_in) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule : ec_event_fifo

// file: logic/ec_device.sv
// Device end: group control, power-up sequencing and tone interrupts
`timescale 1ns/100ps
`include "ec_regs.svh"
module ec_device #(
    parameter int NCH        = 32,
    parameter int NGRP       = 16,
    parameter int FIFO_DEPTH = 64
) (
    input  wire logic            ref_clk_in,
    input  wire logic            rst_in,
    ec_link_if.device            link,
    input  wire logic [NCH-1:0]  tone_detect_in,
    output logic [NCH-1:0]       chan_valid_out,
    output logic [NGRP-1:0]      group_power_out,
    output logic [NGRP-1:0]      group_init_out,
    output logic [NGRP-1:0]      group_passthru_out
);
    ec_pkg::byte_t main_q  [NGRP];
    ec_pkg::byte_t ctrl1_q [NCH];
    ec_pkg::byte_t ctrl2_q [NCH];
    ec_pkg::byte_t test_q;
    ec_pkg::byte_t rdata_q;
    logic [1:0]    init_q  [NGRP];
    logic          busy_q;
    logic          ack_q;
    logic          gap_q;
    logic          fp_q;
    logic          fp_rise;
    logic          pin_rst;
    logic          req;
    logic          wr_hit;
    logic          rd_hit;
    logic          main_sel;
    logic          chan_sel;
    logic [4:0]    chan;
    logic [4:0]    off;
    logic [3:0]    grp;
    logic [NCH-1:0] tone_q;
    logic [NCH-1:0] pend_q;
    logic [NCH-1:0] ev;
    logic [NCH-1:0] take;
    logic [4:0]    pick;
    logic          pick_ok;
    logic          fifo_rdy;
    logic          fifo_vld;
    logic          fifo_pop;
    logic [4:0]    fifo_dout;

    assign pin_rst  = !link.reset_n;
    assign req      = !link.cs_n && (!link.rd_n || !link.wr_n) && !busy_q && !pin_rst;
    assign wr_hit   = req && !link.wr_n;
    assign rd_hit   = req && !link.rd_n && link.wr_n;
    assign main_sel = link.addr[10];
    assign chan_sel = !link.addr[10];
    assign chan     = link.addr[9:5];
    assign off      = link.addr[4:0];
    assign grp      = link.addr[3:0];
    assign fp_rise  = link.frame_pulse_in && !fp_q;
    assign fifo_pop = rd_hit && (link.addr == `FIFO_ADDR);

    // ****************************************
    // Bus handshake
    // ****************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
            ack_q  <= 1'b0;
            gap_q  <= 1'b0;
            fp_q   <= 1'b0;
        end else if (pin_rst || link.cs_n) begin
            busy_q <= 1'b0;
            ack_q  <= 1'b0;
            gap_q  <= 1'b0;
            fp_q   <= link.frame_pulse_in;
        end else begin
            busy_q <= busy_q || req;
            ack_q  <= ack_q || req;
            gap_q  <= gap_q || fifo_pop;
            fp_q   <= link.frame_pulse_in;
        end
    end

    // Outputs released while reset pin low
    assign link.ack_n         = !ack_q;
    assign link.ack_oe_n      = pin_rst;
    assign link.dev_data      = rdata_q;
    assign link.dev_data_oe_n = pin_rst || !ack_q || link.rd_n;
    // Low again for each pending entry
    assign link.irq_n    = !(fifo_vld && !gap_q && !main_q[0][`BIT_GMASK]);
    assign link.irq_oe_n = pin_rst;

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 8'h00;
        end else if (rd_hit) begin
            if (link.addr == `FIFO_ADDR) begin
                rdata_q <= fifo_vld ? {3'h0, fifo_dout} : `FIFO_EMPTY_VAL;
            end else if (link.addr == `TEST_ADDR) begin
                rdata_q <= test_q;
            end else if (main_sel && link.addr[9:4] == 6'h00) begin
                rdata_q <= main_q[grp];
            end else if (chan_sel && off == `OFF_CTRL1) begin
                rdata_q <= ctrl1_q[chan];
            end else if (chan_sel && off == `OFF_CTRL2) begin
                rdata_q <= ctrl2_q[chan];
            end else if (chan_sel && off == `OFF_STATUS) begin
                rdata_q <= 8'(tone_q[chan]) << `BIT_TONE;
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // ****************************************
    // Test register
    // ****************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            test_q <= `TEST_RST;
        end else if (pin_rst) begin
            test_q <= `TEST_RST;
        end else if (wr_hit && link.addr == `TEST_ADDR) begin
            test_q <= link.data_bus;
        end
    end

    // ****************************************
    // Per-group control and initialisation
    // ****************************************
    for (genvar g = 0; g < NGRP; g++) begin : g_grp
        logic wr_main;
        logic rise;
        assign wr_main = wr_hit && main_sel && link.addr[9:4] == 6'h00 && grp == 4'(g);
        assign rise    = wr_main && link.data_bus[`BIT_PWR] && !main_q[g][`BIT_PWR];

        always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
                main_q[g] <= `MAIN_RST;
            end else if (pin_rst) begin
                main_q[g] <= `MAIN_RST;
            end else if (wr_main) begin
                main_q[g] <= link.data_bus;
            end
        end

        always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
                init_q[g] <= 2'h0;
            end else if (pin_rst || (wr_main && !link.data_bus[`BIT_PWR])) begin
                init_q[g] <= 2'h0;
            end else if (rise) begin
                init_q[g] <= `INIT_FRAMES;
            end else if (fp_rise && init_q[g] != 2'h0) begin
                init_q[g] <= init_q[g] - 2'h1;
            end
        end

        for (genvar k = 0; k < 2; k++) begin : g_ec
            localparam int C = 2 * g + k;
            always_ff @(posedge ref_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    ctrl1_q[C] <= (k == 0) ? `CTRL1_A_RST : `CTRL1_B_RST;
                    ctrl2_q[C] <= `CTRL2_RST;
                end else if (pin_rst || rise || init_q[g] != 2'h0) begin
                    ctrl1_q[C] <= (k == 0) ? `CTRL1_A_RST : `CTRL1_B_RST;
                    ctrl2_q[C] <= `CTRL2_RST;
                end else if (wr_hit && chan_sel && chan == 5'(C)) begin
                    if (off == `OFF_CTRL1) begin
                        ctrl1_q[C] <= link.data_bus;
                    end
                    if (off == `OFF_CTRL2) begin
                        ctrl2_q[C] <= link.data_bus;
                    end
                end
            end
        end

        always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
                chan_valid_out[2*g]     <= 1'b0;
                chan_valid_out[2*g+1]   <= 1'b0;
                group_power_out[g]      <= 1'b0;
                group_init_out[g]       <= 1'b0;
                group_passthru_out[g]   <= 1'b1;
            end else begin
                // Both channels valid in normal mode
                chan_valid_out[2*g]     <= 1'b1;
                chan_valid_out[2*g+1]   <= !(ctrl1_q[2*g][`BIT_EXTD] ||
                                             (ctrl1_q[2*g][`BIT_BIDIR] && ctrl1_q[2*g+1][`BIT_BIDIR]));
                group_power_out[g]      <= main_q[g][`BIT_PWR];
                group_init_out[g]       <= init_q[g] != 2'h0;
                group_passthru_out[g]   <= !main_q[g][`BIT_PWR] || pin_rst;
            end
        end

        // Detect both raise and release events on each channel
        assign ev[2*g]   = (tone_detect_in[2*g] ^ tone_q[2*g]) && !main_q[g][`BIT_MASK_A];
        assign ev[2*g+1] = (tone_detect_in[2*g+1] ^ tone_q[2*g+1]) && !main_q[g][`BIT_MASK_B];
    end

    // ****************************************
    // Tone event capture
    // ****************************************
    always_comb begin
        pick    = 5'h00;
        pick_ok = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pick    = 5'(i);
                pick_ok = 1'b1;
            end
        end
        take = (pick_ok && fifo_rdy) ? (NCH'(1) << pick) : '0;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tone_q <= '0;
            pend_q <= '0;
        end else if (pin_rst) begin
            tone_q <= tone_detect_in;
            pend_q <= '0;
        end else begin
            tone_q <= tone_detect_in;
            // New event wins over queue take
            pend_q <= (pend_q & ~take) | ev;
        end
    end

    ec_event_fifo #(
        .W     (5),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .clear_in      (pin_rst),
        .in_valid_in   (pick_ok),
        .in_ready_out  (fifo_rdy),
        .in_data_in    (pick),
        .out_valid_out (fifo_vld),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_dout)
    );
endmodule : ec_device

// file: logic/ec_host.sv
// Host end: reset pin sequencing and bus access for the device
`timescale 1ns/100ps
`include "ec_regs.svh"
module ec_host #(
    parameter int RST_CYC  = `RST_HOLD_CYC,
    parameter int LOCK_CYC = `LOCK_WAIT_CYC
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    ec_link_if.host          link,
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_write_in,
    input  wire logic [10:0] cmd_addr_in,
    input  wire logic [7:0]  cmd_wdata_in,
    output logic             cmd_ready_out,
    output logic             rsp_valid_out,
    output logic [7:0]       rsp_data_out,
    output logic             irq_out
);
    ec_pkg::host_state_t state_q;
    logic [12:0]         cnt_q;
    logic [1:0]          hold_q;
    logic                fp_q;
    logic                wr_q;
    logic [10:0]         addr_q;
    logic [7:0]          wdata_q;
    logic                take;

    assign take          = state_q == ec_pkg::H_IDLE && hold_q == 2'h0 && cmd_valid_in;
    assign cmd_ready_out = state_q == ec_pkg::H_IDLE && hold_q == 2'h0;
    assign link.reset_n        = state_q != ec_pkg::H_RESET;
    assign link.cs_n           = !(state_q == ec_pkg::H_WAIT_ACK);
    assign link.rd_n           = !(state_q == ec_pkg::H_WAIT_ACK && !wr_q);
    assign link.wr_n           = !(state_q == ec_pkg::H_WAIT_ACK && wr_q);
    assign link.addr           = addr_q;
    assign link.host_data      = wdata_q;
    assign link.host_data_oe_n = !(state_q == ec_pkg::H_WAIT_ACK && wr_q);

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ec_pkg::H_RESET;
            cnt_q   <= 13'h0000;
        end else begin
            case (state_q)
                ec_pkg::H_RESET: begin
                    // Hold reset for the minimum time
                    if (cnt_q == 13'(RST_CYC - 1)) begin
                        state_q <= ec_pkg::H_LOCK;
                        cnt_q   <= 13'h0000;
                    end else begin
                        cnt_q <= cnt_q + 13'h0001;
                    end
                end
                ec_pkg::H_LOCK: begin
                    if (cnt_q == 13'(LOCK_CYC - 1)) begin
                        state_q <= ec_pkg::H_IDLE;
                        cnt_q   <= 13'h0000;
                    end else begin
                        cnt_q <= cnt_q + 13'h0001;
                    end
                end
                ec_pkg::H_IDLE: begin
                    if (take) begin
                        state_q <= ec_pkg::H_WAIT_ACK;
                    end
                end
                ec_pkg::H_WAIT_ACK: begin
                    if (!link.ack_line_n) begin
                        state_q <= ec_pkg::H_RELEASE;
                    end
                end
                ec_pkg::H_RELEASE: begin
                    if (link.ack_line_n) begin
                        state_q <= ec_pkg::H_IDLE;
                    end
                end
                default: begin
                    state_q <= ec_pkg::H_RESET;
                    cnt_q   <= 13'h0000;
                end
            endcase
        end
    end

    // ****************************************
    // Command capture
    // ****************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q    <= 1'b0;
            addr_q  <= 11'h000;
            wdata_q <= 8'h00;
        end else if (take) begin
            // Group power-up is a main control write
            wr_q    <= cmd_write_in;
            addr_q  <= cmd_addr_in;
            wdata_q <= cmd_wdata_in;
        end
    end

    // ****************************************
    // Initialisation hold
    // ****************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_q <= 2'h0;
            fp_q   <= 1'b0;
        end else begin
            fp_q <= link.frame_pulse_in;
            // Two frames after a power-up write
            if (state_q == ec_pkg::H_WAIT_ACK && !link.ack_line_n && wr_q && addr_q[10] &&
                wdata_q[`BIT_PWR]) begin
                hold_q <= `INIT_FRAMES;
            end else if (link.frame_pulse_in && !fp_q && hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end
        end
    end

    // ****************************************
    // Answers and interrupt
    // ****************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= 8'h00;
            irq_out       <= 1'b0;
        end else begin
            rsp_valid_out <= state_q == ec_pkg::H_WAIT_ACK && !link.ack_line_n;
            if (state_q == ec_pkg::H_WAIT_ACK && !link.ack_line_n && !wr_q) begin
                rsp_data_out <= link.data_bus;
            end
            // Host software reacts to this flag
            irq_out <= !link.irq_line_n;
        end
    end
endmodule : ec_host

// file: tb/ec_props.sv
// Link checks between host and device ends
`timescale 1ns/100ps
`include "ec_regs.svh"
module ec_props (
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic [10:0] addr,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic [7:0]  data_bus,
    input wire logic        dev_data_oe_n,
    input wire logic        ack_oe_n,
    input wire logic        irq_oe_n,
    input wire logic        ack_line_n,
    input wire logic        irq_line_n,
    input wire logic        reset_n
);
    logic gmask_q;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ************
    // Global mask shadow
    // ************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in)
            gmask_q <= 1'b0;
        else if (!reset_n)
            gmask_q <= 1'b0;
        else if (!cs_n && !wr_n && addr == `MAIN_BASE && $fell(cs_n))
            gmask_q <= data_bus[`BIT_GMASK];
    end
    a_reset_pins_off:
        assert property (!reset_n [*2] |-> ack_oe_n && irq_oe_n && dev_data_oe_n) else $error("pin driven in reset");
    a_reset_bus_float:
        assert property (!reset_n [*2] |-> data_bus == 8'hFF) else $error("bus driven in reset");
    a_ack_on_take:
        assert property ($fell(cs_n) && (!rd_n || !wr_n) && reset_n |=> !ack_line_n) else $error("ack late");
    a_ack_drop_bound:
        assert property ($rose(cs_n) |-> ##[0:1] ack_line_n) else $error("ack held");
    a_read_drives_bus:
        assert property (!ack_line_n && !rd_n && !cs_n |-> !dev_data_oe_n) else $error("read data not driven");
    a_fifo_read_irq:
        assert property ($fell(ack_line_n) && !rd_n && addr == `FIFO_ADDR |=> irq_line_n) else $error("irq low on read");
    a_gmask_quiet_irq:
        assert property (gmask_q && $past(gmask_q) |-> irq_line_n) else $error("irq while masked");
    a_idle_after_reset:
        assert property ($rose(reset_n) |-> irq_line_n [*4]) else $error("irq after reset");
endmodule : ec_props

// file: tb/tb.sv
// Bench joining host and device ends
`timescale 1ns/100ps
module tb;
    logic        ref_clk_in;
    logic        rst_in;
    logic        cmd_valid_in;
    logic        cmd_write_in;
    logic [10:0] cmd_addr_in;
    logic [7:0]  cmd_wdata_in;
    logic        cmd_ready_out;
    logic        rsp_valid_out;
    logic [7:0]  rsp_data_out;
    logic        irq_out;
    logic [31:0] tone_detect_in;
    logic [31:0] chan_valid_out;
    logic [15:0] group_power_out;
    logic [15:0] group_init_out;
    logic [15:0] group_passthru_out;
    logic [7:0]  rd;
    int          n_mismatch;
    int          total_checks;
    int          fcnt;
    int          k;
    // Rows: write, address, data, expected read
    localparam logic [27:0] rows [9] = '{{1'b0, 11'h400, 8'h00, 8'h00}, {1'b0, 11'h410, 8'h00, 8'hFF},
        {1'b0, 11'h411, 8'h00, 8'h00}, {1'b0, 11'h020, 8'h00, 8'h02}, {1'b1, 11'h000, 8'h01, 8'h00},
        {1'b0, 11'h000, 8'h00, 8'h01}, {1'b0, 11'h0A3, 8'h00, 8'h00}, {1'b1, 11'h040, 8'h20, 8'h00},
        {1'b1, 11'h060, 8'h20, 8'h00}};
    ec_link_if link ();
    ec_device ec_device_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link), .tone_detect_in(tone_detect_in),
        .chan_valid_out(chan_valid_out), .group_power_out(group_power_out), .group_init_out(group_init_out),
        .group_passthru_out(group_passthru_out));
    ec_host ec_host_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link),
        .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in), .cmd_addr_in(cmd_addr_in),
        .cmd_wdata_in(cmd_wdata_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_data_out(rsp_data_out), .irq_out(irq_out));
    ec_props ec_props_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr(link.addr), .cs_n(link.cs_n),
        .rd_n(link.rd_n), .wr_n(link.wr_n), .data_bus(link.data_bus), .dev_data_oe_n(link.dev_data_oe_n),
        .ack_oe_n(link.ack_oe_n), .irq_oe_n(link.irq_oe_n), .ack_line_n(link.ack_line_n),
        .irq_line_n(link.irq_line_n), .reset_n(link.reset_n));
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    // Frame pulse every 125 us
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            fcnt                <= 0;
            link.frame_pulse_in <= 1'b0;
        end else begin
            fcnt                <= (fcnt == 1249) ? 0 : fcnt + 1;
            link.frame_pulse_in <= (fcnt == 1249);
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic await(ref logic sig, input int n);
        for (int i = 0; i < n && sig !== 1'b1; i++) @(negedge ref_clk_in);
        if (sig !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
    endtask : await
    task automatic acc(input logic w, input logic [10:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        cmd_valid_in <= 1'b1;
        cmd_write_in <= w;
        cmd_addr_in  <= a;
        cmd_wdata_in <= d;
        @(negedge ref_clk_in);
        await(cmd_ready_out, 8000);
        @(posedge ref_clk_in);
        cmd_valid_in <= 1'b0;
        await(rsp_valid_out, 20);
        rd = rsp_data_out;
    endtask : acc
    initial begin
        rst_in = 1'b1;
        {cmd_valid_in, cmd_write_in, cmd_addr_in, cmd_wdata_in, tone_detect_in} = '0;
        {link.serial_bit_clock, n_mismatch, total_checks} = '0;
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (k = 0; k < 9; k++) begin
            acc(rows[k][27], rows[k][26:16], rows[k][15:8]);
            if (!rows[k][27])
                chk("row read", rows[k][7:0], rd);
        end
        chk("chan valid ext", 8'h05, {4'h0, chan_valid_out[3:0]});
        $display("done rows");
        acc(1'b1, 11'h400, 8'h01);
        chk("group state", 8'h0E, {4'h0, group_power_out[0], group_init_out[0], group_passthru_out[1:0]});
        acc(1'b0, 11'h000, 8'h00);
        chk("ctrl after init", 8'h00, rd);
        chk("chan valid", 8'h03, {6'h00, chan_valid_out[1:0]});
        acc(1'b1, 11'h000, 8'h08);
        acc(1'b0, 11'h000, 8'h00);
        chk("bypass set", 8'h08, rd);
        repeat (1250) @(posedge ref_clk_in);
        acc(1'b1, 11'h000, 8'h00);
        acc(1'b0, 11'h000, 8'h00);
        chk("bypass cleared", 8'h00, rd);
        $display("done power");
        @(posedge ref_clk_in) tone_detect_in <= 32'h0000_0020;
        await(irq_out, 50);
        acc(1'b0, 11'h410, 8'h00);
        chk("fifo", 8'h05, rd);
        acc(1'b0, 11'h0A2, 8'h00);
        chk("status", 8'h01, rd);
        @(posedge ref_clk_in) tone_detect_in <= 32'h0000_0240;
        foreach (rows[j]) if (j < 3) begin
            await(irq_out, 50);
            acc(1'b0, 11'h410, 8'h00);
            chk("fifo order", (j == 0) ? 8'h05 : (j == 1) ? 8'h06 : 8'h09, rd);
        end
        $display("done tones");
        acc(1'b1, 11'h400, 8'h19);
        @(posedge ref_clk_in) tone_detect_in <= 32'h0000_0243;
        acc(1'b0, 11'h410, 8'h00);
        chk("masked fifo", 8'hFF, rd);
        acc(1'b1, 11'h400, 8'h21);
        @(posedge ref_clk_in) tone_detect_in <= 32'h0000_0247;
        repeat (10) @(negedge ref_clk_in);
        chk("irq masked", 8'h00, {7'h00, irq_out});
        acc(1'b1, 11'h400, 8'h01);
        await(irq_out, 50);
        acc(1'b0, 11'h410, 8'h00);
        chk("fifo unmasked", 8'h02, rd);
        $display("done masks");
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        acc(1'b0, 11'h400, 8'h00);
        chk("main after reset", 8'h00, rd);
        $display("done reset");
        conclude();
    end
endmodule : tb
